// ==== hdl/police_params.svh ====
// Offsets, field positions, reset values of the police and drop bank.
`ifndef POLICE_PARAMS_SVH
`define POLICE_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_POINTER     8'h04
`define OFS_CONTROL     8'h0C
`define OFS_RATE        8'h20
`define OFS_BURST       8'h24
`define OFS_MEM_THR     8'h30
`define OFS_MEM_SCALE   8'h34
`define OFS_Q_THR       8'h40
`define OFS_Q_SCALE     8'h44
`define OFS_MONITOR     8'h50

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTL_WIDTH       12
`define PTR_PORT_LSB    16
`define PTR_QUEUE_LSB   0
`define FLD_HI_LSB      16
`define FLD_LO_LSB      0
`define FLD_WIDTH       11
`define HALF_HI_LSB     16
`define HALF_LO_LSB     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTL_RESET       12'h020
`define RATE_RESET      32'h1000_2000
`define BURST_RESET     32'h1000_3000
`define MEM_MAX_RESET   11'h400
`define MEM_MIN_RESET   11'h080
`define MEM_SCALE_RESET 11'h020
`define Q_MAX_RESET     11'h080
`define Q_MIN_RESET     11'h009
`define Q_SCALE_RESET   11'h010

`endif

// ==== hdl/police_pkg.sv ====
// Types shared by the police and drop register bank.
package police_pkg;

  // ----------------------------------------------------------------------
  // Packet colors, encoded as the monitor select field encodes them.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    COLOR_NONE   = 2'h0,
    COLOR_GREEN  = 2'h1,
    COLOR_YELLOW = 2'h2,
    COLOR_RED    = 2'h3
  } color_t;

  // Police control word, bit 11 down to bit 0.
  typedef struct packed {
    logic       dropped_color;
    logic       drop_all;
    logic [1:0] monitor_select;
    logic       port_based;
    logic [1:0] non_ip_frame_color;
    logic       mark_enable;
    logic       remap_enable;
    logic       drop_srp;
    logic       color_blind;
    logic       enable;
  } ctrl_t;

  // One packet presented for a policing and drop decision.
  typedef struct packed {
    logic [2:0]  port;
    logic [1:0]  queue;
    logic        is_ip;
    logic [1:0]  dscp_color;
    logic [1:0]  meter_color;
    logic        srp;
    logic [21:0] random;
  } pkt_req_t;

  // Decision and policing parameters returned for that packet.
  typedef struct packed {
    logic        drop;
    logic [1:0]  color;
    logic        mark_dscp;
    logic [15:0] committed_rate;
    logic [15:0] peak_rate;
    logic [15:0] committed_burst;
    logic [15:0] peak_burst;
  } pkt_result_t;

endpackage

// ==== hdl/port_police_wred_config.sv ====
// Per-port police and random early drop register bank with APB access.
//
// Notes on behaviour
// - Dropped-color bit limits color monitors to drops.
// - Drop-all bit drops all above memory maximum.
// - Monitor select picks red, yellow, green, dropped.
// - Port-based bit; else port zero holds aggregates.
// - Non-IP frames take configured color, reset green.
// - Mark bit enables writing color into DSCP.
// - Remap bit remaps DSCP color when color-aware.
// - Stream reservation packets dropped only if allowed.
// - Mode bit: one color-blind, zero color-aware.
// - Enable bit switches policing and dropping together.
// - Rate word: committed high, peak low, per entry.
// - Burst word: committed high, peak low, per entry.
// - Memory maximum and minimum thresholds, eleven bits.
// - Memory scale writable; memory average read-only.
// - Queue maximum and minimum thresholds per entry.
// - Queue probability scale stored per entry.
// - Queue average size read-only per entry.
// - Pointer register selects port and queue entry.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
`include "police_params.svh"

module port_police_wred_config #(
  parameter int PORTS   = 8,
  parameter int QUEUES  = 4,
  parameter int CNT_W   = 24
) (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // APB slave.
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Average sizes measured by the queue manager.
  input  wire logic [10:0]                mem_avg_size,
  input  wire logic [PORTS*QUEUES*11-1:0] queue_avg_sizes,
  // Packet decision request and result.
  input  wire logic                       pkt_valid,
  input  wire police_pkg::pkt_req_t       pkt,
  output logic                            result_valid,
  output police_pkg::pkt_result_t         result
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  localparam int ENTRIES = PORTS * QUEUES;

  police_pkg::ctrl_t ctrl;                   // Police control word.
  logic [2:0]        port_index;             // Pointer: port.
  logic [1:0]        queue_ptr;              // Pointer: queue.
  logic [10:0]       mem_max;                // Memory maximum threshold.
  logic [10:0]       mem_min;                // Memory minimum threshold.
  logic [10:0]       memory_drop_probability_scale; // Memory scale.
  logic [31:0]       rate_word  [ENTRIES];   // Committed and peak rate.
  logic [31:0]       burst_word [ENTRIES];   // Committed and peak burst.
  logic [10:0]       q_max      [ENTRIES];   // Queue maximum threshold.
  logic [10:0]       q_min      [ENTRIES];   // Queue minimum threshold.
  logic [10:0]       q_scale    [ENTRIES];   // Queue probability scale.
  logic [CNT_W-1:0]  cnt_drop   [ENTRIES];   // Dropped packet count.
  logic [CNT_W-1:0]  cnt_green  [ENTRIES];   // Green performance_monitor.
  logic [CNT_W-1:0]  cnt_yellow [ENTRIES];   // Yellow performance_monitor.
  logic [CNT_W-1:0]  cnt_red    [ENTRIES];   // Red performance_monitor.

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire        setup     = psel & ~penable;
  wire        access    = psel & penable;
  wire        hit_ptr   = (paddr == `OFS_POINTER);
  wire        hit_ctl   = (paddr == `OFS_CONTROL);
  wire        hit_rate  = (paddr == `OFS_RATE);
  wire        hit_burst = (paddr == `OFS_BURST);
  wire        hit_mthr  = (paddr == `OFS_MEM_THR);
  wire        hit_mscl  = (paddr == `OFS_MEM_SCALE);
  wire        hit_qthr  = (paddr == `OFS_Q_THR);
  wire        hit_qscl  = (paddr == `OFS_Q_SCALE);
  wire        hit_mon   = (paddr == `OFS_MONITOR);
  wire        mapped    = hit_ptr | hit_ctl | hit_rate | hit_burst |
                          hit_mthr | hit_mscl | hit_qthr | hit_qscl |
                          hit_mon;
  wire        wr_en     = access & pwrite & mapped;
  // Register accesses use the software pointers directly.
  wire [4:0]  sel_entry = {port_index, queue_ptr};
  // Field slices of the write data.
  wire [10:0] wr_hi     = pwdata[`FLD_HI_LSB +: `FLD_WIDTH];
  wire [10:0] wr_lo     = pwdata[`FLD_LO_LSB +: `FLD_WIDTH];
  wire [10:0] sel_q_avg = queue_avg_sizes[sel_entry*11 +: 11];

  // Zero wait states; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  // Monitor count chosen by the select field.
  logic [CNT_W-1:0] mon_count;
  always_comb begin
    case (ctrl.monitor_select)
      2'h3:    mon_count = cnt_red[sel_entry];
      2'h2:    mon_count = cnt_yellow[sel_entry];
      2'h1:    mon_count = cnt_green[sel_entry];
      default: mon_count = cnt_drop[sel_entry];
    endcase
  end

  // Unused bits of every word are zero-filled here.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ptr) begin
      rd_mux[`PTR_PORT_LSB +: 3]  = port_index;
      rd_mux[`PTR_QUEUE_LSB +: 2] = queue_ptr;
    end
    if (hit_ctl) begin
      rd_mux[`CTL_WIDTH-1:0] = ctrl;
    end
    if (hit_rate) begin
      rd_mux = rate_word[sel_entry];
    end
    if (hit_burst) begin
      rd_mux = burst_word[sel_entry];
    end
    if (hit_mthr) begin
      rd_mux[`FLD_HI_LSB +: `FLD_WIDTH] = mem_max;
      rd_mux[`FLD_LO_LSB +: `FLD_WIDTH] = mem_min;
    end
    if (hit_mscl) begin
      rd_mux[`FLD_HI_LSB +: `FLD_WIDTH] = memory_drop_probability_scale;
      rd_mux[`FLD_LO_LSB +: `FLD_WIDTH] = mem_avg_size;
    end
    if (hit_qthr) begin
      rd_mux[`FLD_HI_LSB +: `FLD_WIDTH] = q_max[sel_entry];
      rd_mux[`FLD_LO_LSB +: `FLD_WIDTH] = q_min[sel_entry];
    end
    if (hit_qscl) begin
      rd_mux[`FLD_HI_LSB +: `FLD_WIDTH] = q_scale[sel_entry];
      rd_mux[`FLD_LO_LSB +: `FLD_WIDTH] = sel_q_avg;
    end
    if (hit_mon) begin
      rd_mux[CNT_W-1:0] = mon_count;
    end
  end

  // Read data is captured in the setup cycle so prdata comes from a
  // flop and is stable for the whole access phase.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Global registers
  // ----------------------------------------------------------------------
  // Pointer, control and memory thresholds; only defined bits store.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_index                    <= 3'h0;
      queue_ptr                     <= 2'h0;
      ctrl                          <= `CTL_RESET;
      mem_max                       <= `MEM_MAX_RESET;
      mem_min                       <= `MEM_MIN_RESET;
      memory_drop_probability_scale <= `MEM_SCALE_RESET;
    end else if (wr_en) begin
      if (hit_ptr) begin
        port_index <= pwdata[`PTR_PORT_LSB +: 3];
        queue_ptr  <= pwdata[`PTR_QUEUE_LSB +: 2];
      end
      if (hit_ctl) begin
        ctrl <= pwdata[`CTL_WIDTH-1:0];
      end
      if (hit_mthr) begin
        mem_max <= wr_hi;
        mem_min <= wr_lo;
      end
      if (hit_mscl) begin
        memory_drop_probability_scale <= wr_hi;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Packet decision
  // ----------------------------------------------------------------------
  // Without port-based policing all ports share the port zero entry.
  wire [4:0]  pkt_entry = {pkt.port, pkt.queue};
  wire [4:0]  pol_entry = ctrl.port_based ? pkt_entry
                                          : {3'h0, pkt.queue};
  wire [10:0] pkt_q_avg = queue_avg_sizes[pkt_entry*11 +: 11];

  // Ingress color before metering: non-IP frames use the configured
  // color, IP frames the DSCP color, optionally remapped one step worse.
  wire [1:0] dscp_remap = (pkt.dscp_color == 2'h3) ? 2'h3
                          : 2'(pkt.dscp_color + 2'h1);
  wire [1:0] dscp_used  = ctrl.remap_enable ? dscp_remap
                                            : pkt.dscp_color;
  wire [1:0] in_color   = pkt.is_ip ? dscp_used
                                    : ctrl.non_ip_frame_color;
  // Color-aware keeps the worse of ingress and meter color.
  wire [1:0] aware_color = (in_color > pkt.meter_color) ? in_color
                                                        : pkt.meter_color;
  wire [1:0] out_color  = ctrl.color_blind ? pkt.meter_color
                                           : aware_color;

  // Drop probability: distance above minimum times scale, compared
  // against the packet's random number. Saturating is not needed since
  // 11 by 11 bits fits the 22-bit random range exactly.
  wire [10:0] m_dist = 11'(mem_avg_size - mem_min);
  wire [10:0] q_dist = 11'(pkt_q_avg - q_min[pol_entry]);
  wire [21:0] m_prob = 22'(m_dist * memory_drop_probability_scale);
  wire [21:0] q_prob = 22'(q_dist * q_scale[pol_entry]);
  wire [21:0] m_full = {memory_drop_probability_scale, 11'h000};
  wire        m_over = mem_avg_size > mem_max;
  wire        m_mid  = !m_over && (mem_avg_size >= mem_min);
  wire        q_over = pkt_q_avg > q_max[pol_entry];
  wire        q_mid  = !q_over && (pkt_q_avg >= q_min[pol_entry]);
  wire        m_drop = m_over ? (ctrl.drop_all || pkt.random < m_full)
                       : (m_mid && pkt.random < m_prob);
  wire        q_drop = q_over || (q_mid && pkt.random < q_prob);
  wire        srp_ok = !pkt.srp || ctrl.drop_srp;
  wire        drop   = ctrl.enable && srp_ok && (m_drop || q_drop);

  // Next result; the policing fields come from the chosen entry.
  police_pkg::pkt_result_t next_result;
  always_comb begin
    next_result                 = '0;
    next_result.drop            = drop;
    next_result.color           = ctrl.enable ? out_color : 2'h1;
    next_result.mark_dscp       = ctrl.enable && ctrl.mark_enable;
    next_result.committed_rate  = rate_word[pol_entry][`HALF_HI_LSB +: 16];
    next_result.peak_rate       = rate_word[pol_entry][`HALF_LO_LSB +: 16];
    next_result.committed_burst = burst_word[pol_entry][`HALF_HI_LSB +: 16];
    next_result.peak_burst      = burst_word[pol_entry][`HALF_LO_LSB +: 16];
  end

  // Result registered one cycle after the request.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_valid <= 1'b0;
      result       <= '0;
    end else begin
      result_valid <= pkt_valid;
      if (pkt_valid) begin
        result <= next_result;
      end
    end
  end

  // Counting only happens while the bank is enabled.
  wire count_en  = pkt_valid && ctrl.enable;
  wire color_cnt = count_en && (!ctrl.dropped_color || drop);

  // ----------------------------------------------------------------------
  // Per-entry storage and counters
  // ----------------------------------------------------------------------
  // Counters follow the real port, not the aggregated entry, so the
  // monitor still reports per port in per-queue policing mode.
  for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
    wire sel_here = (sel_entry == 5'(e));
    wire pkt_here = (pkt_entry == 5'(e));
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        rate_word[e]  <= `RATE_RESET;
        burst_word[e] <= `BURST_RESET;
        q_max[e]      <= `Q_MAX_RESET;
        q_min[e]      <= `Q_MIN_RESET;
        q_scale[e]    <= `Q_SCALE_RESET;
      end else if (wr_en && sel_here) begin
        if (hit_rate) begin
          rate_word[e] <= pwdata;
        end
        if (hit_burst) begin
          burst_word[e] <= pwdata;
        end
        if (hit_qthr) begin
          q_max[e] <= wr_hi;
          q_min[e] <= wr_lo;
        end
        if (hit_qscl) begin
          q_scale[e] <= wr_hi;
        end
      end
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cnt_drop[e]   <= '0;
        cnt_green[e]  <= '0;
        cnt_yellow[e] <= '0;
        cnt_red[e]    <= '0;
      end else if (pkt_here) begin
        if (count_en && drop) begin
          cnt_drop[e] <= cnt_drop[e] + 1'b1;
        end
        if (color_cnt && next_result.color == 2'h1) begin
          cnt_green[e] <= cnt_green[e] + 1'b1;
        end
        if (color_cnt && next_result.color == 2'h2) begin
          cnt_yellow[e] <= cnt_yellow[e] + 1'b1;
        end
        if (color_cnt && next_result.color == 2'h3) begin
          cnt_red[e] <= cnt_red[e] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_ctl_write;
    access && pwrite && hit_ctl;
  endsequence

  sequence s_read_setup;
    setup && !pwrite;
  endsequence

  a_disabled_no_drop: assert property (
    pkt_valid && !ctrl.enable |=> result_valid && !result.drop)
    else $error("drop while disabled");

  a_srp_protected: assert property (
    pkt_valid && pkt.srp && !ctrl.drop_srp |=> !result.drop)
    else $error("protected srp packet dropped");

  a_drop_all_max: assert property (
    pkt_valid && ctrl.enable && ctrl.drop_all && srp_ok &&
    mem_avg_size > mem_max |=> result.drop)
    else $error("drop-all above maximum missed");

  a_below_min_keep: assert property (
    pkt_valid && mem_avg_size < mem_min && pkt_q_avg < q_min[pol_entry]
    |=> !result.drop)
    else $error("drop below minimum");

  a_blind_color: assert property (
    pkt_valid && ctrl.enable && ctrl.color_blind
    |=> result.color == $past(pkt.meter_color))
    else $error("color-blind color wrong");

  a_mark_follows: assert property (
    pkt_valid |=> result.mark_dscp == $past(ctrl.enable && ctrl.mark_enable))
    else $error("dscp mark wrong");

  a_reserved_ctl: assert property (
    s_ctl_write ##1 s_read_setup ##0 hit_ctl |=> prdata[31:12] == 20'h0)
    else $error("reserved control bits not zero");

  a_ptr_readback: assert property (
    access && pwrite && hit_ptr |=> port_index == $past(pwdata[18:16]) &&
    queue_ptr == $past(pwdata[1:0]))
    else $error("pointer write lost");

  a_shared_rate: assert property (
    pkt_valid && !ctrl.port_based |=>
    result.committed_rate == $past(rate_word[{3'h0, pkt.queue}][31:16]))
    else $error("aggregated rate not from port zero");

  a_mem_avg_read: assert property (
    s_read_setup ##0 hit_mscl |=> prdata[10:0] == $past(mem_avg_size))
    else $error("memory average readback wrong");

endmodule

// ==== tb/port_police_wred_config_tb.sv ====
// Self-checking bench for the police and drop register bank.
`timescale 1ns/10ps
`include "police_params.svh"

module port_police_wred_config_tb;
  // ----------------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------------
  logic                   clk;        // Bus and packet clock.
  logic                   nrst;       // Active-low reset.
  logic                   psel;       // APB select.
  logic                   penable;    // APB access phase.
  logic                   pwrite;     // APB direction.
  logic [7:0]             paddr;      // APB byte address.
  logic [31:0]            pwdata;     // APB write data.
  logic [31:0]            prdata;     // APB read data.
  logic                   pready;     // APB ready.
  logic                   pslverr;    // APB error.
  logic [10:0]            mem_avg;    // Memory average size.
  logic [32*11-1:0]       qavg;       // Per-entry average sizes.
  logic                   pkt_valid;  // Packet request strobe.
  police_pkg::pkt_req_t   pkt;        // Packet request.
  logic                   res_valid;  // Decision strobe.
  police_pkg::pkt_result_t res;       // Decision.
  logic [31:0]            rd;         // Last read word.
  logic                   err;        // Error seen in last access.
  int                     fails;      // Mismatches so far.
  int                     checked;    // Comparisons so far.

  port_police_wred_config i_port_police_wred_config (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_avg_size(mem_avg),
    .queue_avg_sizes(qavg), .pkt_valid(pkt_valid), .pkt(pkt),
    .result_valid(res_valid), .result(res));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic final_report;
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares one value with its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // One APB transfer; the wait for ready is bounded so a hang ends the run.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sends one packet and waits out the fixed one-cycle decision latency.
  // The one-cycle strobe is looked at mid-cycle, where it has settled,
  // not at the edge that already launches its fall.
  task automatic send(input logic [2:0] p, input logic [1:0] q,
                      input logic ip, input logic [1:0] dc,
                      input logic [1:0] mc, input logic s);
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt <= {p, q, ip, dc, mc, s, 22'h3FFFFF};
    @(posedge clk);
    pkt_valid <= 1'b0;
    @(negedge clk);
    check({31'h0, res_valid}, 32'h1, "result strobe");
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset values, with the read-only averages taken from the inputs.
  task automatic reset_values;
    apb(0, `OFS_CONTROL, 0);   check(rd, 32'h0000_0020, "ctl");
    apb(0, `OFS_POINTER, 0);   check(rd, 32'h0, "ptr");
    apb(0, `OFS_RATE, 0);      check(rd, 32'h1000_2000, "rate");
    apb(0, `OFS_BURST, 0);     check(rd, 32'h1000_3000, "burst");
    apb(0, `OFS_MEM_THR, 0);   check(rd, 32'h0400_0080, "mthr");
    apb(0, `OFS_MEM_SCALE, 0); check(rd, 32'h0020_0010, "msc");
    apb(0, `OFS_Q_THR, 0);     check(rd, 32'h0080_0009, "qthr");
    apb(0, `OFS_Q_SCALE, 0);   check(rd, 32'h0010_0100, "qsc");
  endtask

  // All-ones writes must leave reserved and read-only bits alone.
  task automatic reserved_bits;
    apb(1, `OFS_CONTROL, 32'hFFFF_FFFF);
    apb(0, `OFS_CONTROL, 0);   check(rd, 32'h0000_0FFF, "ctl");
    apb(1, `OFS_POINTER, 32'hFFFF_FFFF);
    apb(0, `OFS_POINTER, 0);   check(rd, 32'h0007_0003, "ptr");
    apb(1, `OFS_MEM_THR, 32'hFFFF_FFFF);
    apb(0, `OFS_MEM_THR, 0);   check(rd, 32'h07FF_07FF, "mthr");
    apb(1, `OFS_MEM_SCALE, 32'hFFFF_FFFF);
    apb(0, `OFS_MEM_SCALE, 0); check(rd, 32'h07FF_0010, "msc");
    apb(1, `OFS_MEM_THR, 32'h0400_0080);
    apb(1, `OFS_MEM_SCALE, 32'h0020_0000);
  endtask

  // Unmapped place: error flagged, zero read, write dropped.
  task automatic unmapped;
    apb(1, 8'h08, 32'hFFFF_FFFF); check({31'h0, err}, 32'h1, "werr");
    apb(0, 8'h08, 0);             check({31'h0, err}, 32'h1, "rerr");
    check(rd, 32'h0, "rzero");
  endtask

  // Indexed entries: port 5 queue 2 differs from port 0 queue 2.
  task automatic indexed;
    apb(1, `OFS_CONTROL, 32'h0000_0081);
    apb(1, `OFS_POINTER, 32'h0005_0002);
    apb(1, `OFS_RATE, 32'h1234_5678);
    apb(1, `OFS_Q_THR, 32'hFFFF_FFFF);
    apb(0, `OFS_Q_THR, 0);   check(rd, 32'h07FF_07FF, "qthr");
    apb(1, `OFS_Q_SCALE, 32'h07FF_07FF);
    apb(0, `OFS_Q_SCALE, 0); check(rd, 32'h07FF_0056, "qsc");
    apb(1, `OFS_Q_SCALE, 32'h0010_0000);
    apb(1, `OFS_POINTER, 32'h0000_0002);
    apb(0, `OFS_RATE, 0);    check(rd, 32'h1000_2000, "rate0");
    send(3'h5, 2'h2, 1, 2'h1, 2'h1, 0);
    check(res.committed_rate, 32'h1234, "own cr");
    check(res.peak_rate, 32'h5678, "own pr");
    apb(1, `OFS_CONTROL, 32'h0000_0001);
    send(3'h5, 2'h2, 1, 2'h1, 2'h1, 0);
    check(res.committed_rate, 32'h1000, "agg cr");
    check(res.peak_burst, 32'h3000, "agg pb");
    check(res.committed_burst, 32'h1000, "agg cb");
  endtask

  // Color choice, marking, enable and drop decisions.
  task automatic decisions;
    apb(1, `OFS_CONTROL, 32'h0000_0000);
    send(0, 0, 1, 2'h1, 2'h3, 0);
    check({res.drop, res.color}, 32'h1, "off");
    check(res.mark_dscp, 32'h0, "off mark");
    apb(1, `OFS_CONTROL, 32'h0000_0003);
    send(0, 1, 1, 2'h1, 2'h2, 0);
    check({res.drop, res.color}, 32'h2, "blind");
    apb(1, `OFS_CONTROL, 32'h0000_0061);
    send(0, 1, 0, 2'h1, 2'h1, 0);
    check(res.color, 32'h3, "non ip");
    apb(1, `OFS_CONTROL, 32'h0000_0019);
    send(0, 1, 1, 2'h1, 2'h1, 0);
    check(res.color, 32'h2, "remap");
    check(res.mark_dscp, 32'h1, "mark");
    apb(1, `OFS_CONTROL, 32'h0000_0001);
    send(0, 0, 1, 2'h1, 2'h1, 1);
    check(res.drop, 32'h0, "srp kept");
    send(0, 0, 1, 2'h1, 2'h1, 0);
    check(res.drop, 32'h1, "above max");
    send(0, 1, 1, 2'h1, 2'h1, 0);
    check(res.drop, 32'h0, "below min");
    apb(1, `OFS_CONTROL, 32'h0000_0005);
    send(0, 0, 1, 2'h1, 2'h1, 1);
    check(res.drop, 32'h1, "srp drop");
    mem_avg <= 11'h500;
    apb(1, `OFS_CONTROL, 32'h0000_0001);
    send(0, 1, 1, 2'h1, 2'h1, 0);
    check(res.drop, 32'h0, "scaled");
    apb(1, `OFS_CONTROL, 32'h0000_0401);
    send(0, 1, 1, 2'h1, 2'h1, 0);
    check(res.drop, 32'h1, "drop all");
    mem_avg <= 11'h010;
    apb(1, `OFS_CONTROL, 32'h0000_0001);
    apb(1, `OFS_POINTER, 32'h0);
    apb(0, `OFS_MONITOR, 0); check(rd, 32'h2, "drop count");
    // Entry 0 saw three green packets while enabled.
    apb(1, `OFS_CONTROL, 32'h0000_0101);
    apb(0, `OFS_MONITOR, 0); check(rd, 32'h3, "green count");
    // With the dropped-color bit only the dropped green one counts.
    apb(1, `OFS_CONTROL, 32'h0000_0901);
    send(0, 0, 1, 2'h1, 2'h1, 0);
    send(0, 0, 1, 2'h1, 2'h1, 1);
    apb(0, `OFS_MONITOR, 0); check(rd, 32'h4, "dropped green");
    // Entry 1 saw two yellow packets and one red one.
    apb(1, `OFS_POINTER, 32'h0000_0001);
    apb(1, `OFS_CONTROL, 32'h0000_0201);
    apb(0, `OFS_MONITOR, 0); check(rd, 32'h2, "yellow count");
    apb(1, `OFS_CONTROL, 32'h0000_0301);
    apb(0, `OFS_MONITOR, 0); check(rd, 32'h1, "red count");
  endtask

  // ----------------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------------
  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Entry 0 sits above its maximum and entry 1 below its minimum.
  initial begin
    fails = 0;
    checked = 0;
    nrst = 1'b0;
    {psel, penable, pwrite, pkt_valid} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pkt = '0;
    mem_avg = 11'h010;
    for (int e = 0; e < 32; e++) begin
      qavg[e*11 +: 11] = 11'h040 + 11'(e);
    end
    qavg[10:0] = 11'h100;
    qavg[21:11] = 11'h004;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    reset_values();
    reserved_bits();
    unmapped();
    indexed();
    decisions();
    final_report();
  end
endmodule
